// File: flash_seq_pkg.sv
package flash_seq_pkg;

  // Bus widths of the command and register ports
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // Command codes seen in the first or second bus cycle
  localparam logic [DATA_W-1:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [DATA_W-1:0] CMD_READ_STATUS = 8'h70;
  localparam logic [DATA_W-1:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [DATA_W-1:0] CMD_PROGRAM = 8'h40;
  localparam logic [DATA_W-1:0] CMD_ERASE = 8'h20;
  localparam logic [DATA_W-1:0] CMD_ERASE_CONFIRM = 8'hD0;

  // Register offsets on the plain register port
  localparam logic [1:0] OFF_CTRL_A = 2'h0;
  localparam logic [1:0] OFF_CTRL_B = 2'h1;
  localparam logic [1:0] OFF_STATUS = 2'h2;
  localparam logic [1:0] OFF_MODE = 2'h3;

  // Field positions in flash_control_reg_a
  localparam int CTRL_A_READY_BIT = 0;
  localparam int CTRL_A_REWRITE_EN_BIT = 2;
  localparam int CTRL_A_PROG_ERR_BIT = 6;
  localparam int CTRL_A_ERASE_ERR_BIT = 7;

  // Field positions in flash_control_reg_b
  localparam int CTRL_B_LOCK0_BIT = 5;
  localparam int CTRL_B_LOCK1_BIT = 6;

  // Field positions in the readable status byte
  localparam int STATUS_PROG_BIT = 4;
  localparam int STATUS_ERASE_BIT = 5;
  localparam int STATUS_READY_BIT = 7;

  // Values after reset
  localparam logic REWRITE_EN_RST = 1'b0;
  localparam logic LOCK_RST = 1'b0;

  // Blocks 0 to 3 are guarded by the global rewrite enable
  localparam int PROT_BLOCKS = 4;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_READ_ARRAY = 3'b000,
    ST_READ_STATUS = 3'b001,
    ST_PROG_DATA = 3'b010,
    ST_ERASE_CONFIRM = 3'b011,
    ST_PROG_BUSY = 3'b100,
    ST_ERASE_BUSY = 3'b101
  } seq_state_t;

  // Error code: bit 1 is the erase-error flag, bit 0 the program-error flag
  typedef enum logic [1:0] {
    ERR_NONE = 2'b00,
    ERR_PROGRAM = 2'b01,
    ERR_ERASE = 2'b10,
    ERR_SEQUENCE = 2'b11
  } err_code_t;

  // One command bus cycle from the CPU
  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } cmd_wr_t;

  // Start request to the flash array engine
  typedef struct packed {
    logic prog;
    logic erase;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } op_req_t;

  // Completion report from the flash array engine
  typedef struct packed {
    logic done;
    logic fail;
  } op_rsp_t;

endpackage

// File: flash_command_error_status.sv
// Summary of operation
// - Any error sets flags by error class
// - Malformed sequence sets both error flags
// - Erase second cycle not D0h/FFh errors
// - Rewrite-disabled program or erase errors
// - Erase address outside flash errors
// - Erase of locked block errors
// - Program address outside flash errors
// - Program of locked block errors
// - Failed auto-erase sets erase flag only
// - Failed auto-program sets program flag only
// - FFh in second cycle enters read array
// - Abort discards the latched first command
// - Clear status zeroes both error flags
// - Set flags refuse new program/erase
// - Enable bit guards blocks 0-3, lock bits guard blocks 0 and 1
//
// The address-and-strobe port and the address map were left to the implementer.
module flash_command_error_status
  import flash_seq_pkg::*;
#(
  parameter logic [ADDR_W-1:0] FLASH_BASE = 16'h8000,
  parameter int BLOCK_W = 13,
  parameter int NUM_BLOCKS = 4
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire cmd_wr_t CMD,
  input wire logic [1:0] REG_ADDR,
  input wire logic [DATA_W-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [DATA_W-1:0] REG_RDATA,
  output op_req_t OP_REQ,
  input wire op_rsp_t OP_RSP,
  output logic READ_STATUS_MODE,
  output err_code_t ERROR_CODE
);

  // Width of the block index taken from the offset into flash
  localparam int BLK_W = ADDR_W - BLOCK_W + 1;
  localparam logic [ADDR_W:0] FLASH_SPAN = (ADDR_W + 1)'(NUM_BLOCKS << BLOCK_W);

  // Sequencer state
  seq_state_t state;
  seq_state_t next_state;
  err_code_t err;
  err_code_t next_err;
  logic [ADDR_W-1:0] first_addr;
  logic [ADDR_W-1:0] next_first_addr;
  op_req_t next_op;
  logic next_status_mode;

  // Software-owned protection bits
  logic global_rewrite_enable;
  logic block0_rewrite_lock;
  logic block1_rewrite_lock;

  // Address decode of the current command cycle
  logic [ADDR_W:0] flash_off;
  logic [BLK_W-1:0] blk;
  logic addr_in_flash;
  logic blk_protected;
  logic addr_mismatch;
  logic prog_fault;
  logic erase_fault;
  logic is_abort;
  logic is_confirm;
  logic flags_clear;
  logic busy;

  // Register port decode
  logic wr_ctrl_a;
  logic wr_ctrl_b;
  logic [DATA_W-1:0] ctrl_a_value;
  logic [DATA_W-1:0] ctrl_b_value;
  logic [DATA_W-1:0] status_value;
  logic [DATA_W-1:0] mode_value;
  logic [DATA_W-1:0] read_mux;
  logic [DATA_W-1:0] next_rdata;

  // Offset is one bit wider so that an address below the base shows as negative
  assign flash_off = {1'b0, CMD.addr} - {1'b0, FLASH_BASE};
  assign blk = flash_off[ADDR_W:BLOCK_W];
  assign addr_in_flash = !flash_off[ADDR_W] && (flash_off < FLASH_SPAN);

  // Global enable covers blocks 0-3, each lock narrows to one block
  assign blk_protected =
    (!global_rewrite_enable && (blk < BLK_W'(PROT_BLOCKS))) ||
    (block0_rewrite_lock && (blk == BLK_W'(0))) ||
    (block1_rewrite_lock && (blk == BLK_W'(1)));

  // Program data must go to the address given in the first cycle
  assign addr_mismatch = CMD.addr != first_addr;

  // Second-cycle checks for each command
  assign prog_fault = !addr_in_flash || blk_protected || addr_mismatch;
  assign erase_fault = !is_confirm || !addr_in_flash || blk_protected;

  // Data codes of interest in a second cycle
  assign is_abort = CMD.data == CMD_READ_ARRAY;
  assign is_confirm = CMD.data == CMD_ERASE_CONFIRM;

  // No error pending, so program and erase may start
  assign flags_clear = err == ERR_NONE;

  // Sequencer is busy while the array engine works
  assign busy = (state == ST_PROG_BUSY) || (state == ST_ERASE_BUSY);

  // Command sequencer: decodes bus cycles and classifies errors
  always_comb begin
    next_state = state;
    next_err = err;
    next_first_addr = first_addr;
    next_op = '0;
    unique case (state)
      ST_READ_ARRAY, ST_READ_STATUS: begin
        if (CMD.valid) begin
          unique case (CMD.data)
            CMD_READ_ARRAY: begin
              next_state = ST_READ_ARRAY;
            end
            CMD_READ_STATUS: begin
              next_state = ST_READ_STATUS;
            end
            CMD_CLEAR_STATUS: begin
              next_err = ERR_NONE;
            end
            CMD_PROGRAM: begin
              if (flags_clear) begin
                next_state = ST_PROG_DATA;
                next_first_addr = CMD.addr;
              end
            end
            CMD_ERASE: begin
              if (flags_clear) begin
                next_state = ST_ERASE_CONFIRM;
                next_first_addr = CMD.addr;
              end
            end
            default: begin
              next_err = ERR_SEQUENCE;
              next_state = ST_READ_STATUS;
            end
          endcase
        end
      end
      ST_PROG_DATA: begin
        if (CMD.valid) begin
          if (is_abort) begin
            // Leaving the state drops the latched program code
            next_state = ST_READ_ARRAY;
          end else if (prog_fault) begin
            next_err = ERR_SEQUENCE;
            next_state = ST_READ_STATUS;
          end else begin
            next_op.prog = 1'b1;
            next_op.addr = CMD.addr;
            next_op.data = CMD.data;
            next_state = ST_PROG_BUSY;
          end
        end
      end
      ST_ERASE_CONFIRM: begin
        if (CMD.valid) begin
          if (is_abort) begin
            // Leaving the state drops the latched erase code
            next_state = ST_READ_ARRAY;
          end else if (erase_fault) begin
            next_err = ERR_SEQUENCE;
            next_state = ST_READ_STATUS;
          end else begin
            next_op.erase = 1'b1;
            next_op.addr = CMD.addr;
            next_state = ST_ERASE_BUSY;
          end
        end
      end
      ST_PROG_BUSY: begin
        // Command cycles are ignored until the engine reports back
        if (OP_RSP.done) begin
          next_state = ST_READ_STATUS;
          if (OP_RSP.fail) begin
            next_err = ERR_PROGRAM;
          end
        end
      end
      ST_ERASE_BUSY: begin
        if (OP_RSP.done) begin
          next_state = ST_READ_STATUS;
          if (OP_RSP.fail) begin
            next_err = ERR_ERASE;
          end
        end
      end
      default: begin
        next_state = ST_READ_ARRAY;
      end
    endcase
  end

  // Any state other than read array presents the status byte to reads
  assign next_status_mode = next_state != ST_READ_ARRAY;

  // Sequencer registers
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      state <= ST_READ_ARRAY;
      err <= ERR_NONE;
      first_addr <= '0;
    end else if (CE) begin
      state <= next_state;
      err <= next_err;
      first_addr <= next_first_addr;
    end
  end

  // Outputs toward the array engine and the CPU, all from flip-flops
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      OP_REQ <= '0;
      READ_STATUS_MODE <= 1'b0;
      ERROR_CODE <= ERR_NONE;
    end else if (CE) begin
      OP_REQ <= next_op;
      READ_STATUS_MODE <= next_status_mode;
      ERROR_CODE <= next_err;
    end
  end

  // Register write strobes
  assign wr_ctrl_a = REG_WR && (REG_ADDR == OFF_CTRL_A);
  assign wr_ctrl_b = REG_WR && (REG_ADDR == OFF_CTRL_B);

  // Protection bits; a change takes effect on the next command cycle
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      global_rewrite_enable <= REWRITE_EN_RST;
      block0_rewrite_lock <= LOCK_RST;
      block1_rewrite_lock <= LOCK_RST;
    end else if (CE) begin
      if (wr_ctrl_a) begin
        global_rewrite_enable <= REG_WDATA[CTRL_A_REWRITE_EN_BIT];
      end
      if (wr_ctrl_b) begin
        block0_rewrite_lock <= REG_WDATA[CTRL_B_LOCK0_BIT];
        block1_rewrite_lock <= REG_WDATA[CTRL_B_LOCK1_BIT];
      end
    end
  end

  // Read views; error flags are read-only and cleared only by command
  assign ctrl_a_value = DATA_W'(
    ({7'h00, err[1]} << CTRL_A_ERASE_ERR_BIT) |
    ({7'h00, err[0]} << CTRL_A_PROG_ERR_BIT) |
    ({7'h00, global_rewrite_enable} << CTRL_A_REWRITE_EN_BIT) |
    ({7'h00, !busy} << CTRL_A_READY_BIT));
  assign ctrl_b_value = DATA_W'(
    ({7'h00, block1_rewrite_lock} << CTRL_B_LOCK1_BIT) |
    ({7'h00, block0_rewrite_lock} << CTRL_B_LOCK0_BIT));

  // Status byte mirrors the same flags, so one clear resets both views
  assign status_value = DATA_W'(
    ({7'h00, !busy} << STATUS_READY_BIT) |
    ({7'h00, err[1]} << STATUS_ERASE_BIT) |
    ({7'h00, err[0]} << STATUS_PROG_BIT));
  assign mode_value = {5'h00, state};

  // Read data mux
  assign read_mux =
    (REG_ADDR == OFF_CTRL_A) ? ctrl_a_value :
    (REG_ADDR == OFF_CTRL_B) ? ctrl_b_value :
    (REG_ADDR == OFF_STATUS) ? status_value : mode_value;

  // Data stand only in the cycle after the read strobe
  assign next_rdata = REG_RD ? read_mux : 8'h00;

  // Read data register
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      REG_RDATA <= 8'h00;
    end else if (CE) begin
      REG_RDATA <= next_rdata;
    end
  end

endmodule

// File: flash_engine_model.sv
module flash_engine_model
  import flash_seq_pkg::*;
(
  input wire logic mclk,
  input wire op_req_t req,
  input wire logic fail_en,
  input wire logic [2:0] lat,
  output op_rsp_t rsp = '0
);
  logic [3:0] cnt = 4'h0;
  // Finishes lat+1 cycles after a start; fail toggles outside done so it is never trusted
  always_ff @(posedge mclk) begin
    rsp.done <= 1'b0;
    rsp.fail <= ~rsp.fail;
    if (req.prog || req.erase) begin
      cnt <= {1'b0, lat} + 4'h1;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
      if (cnt == 4'h1) begin
        rsp.done <= 1'b1;
        rsp.fail <= fail_en;
      end
    end
  end
endmodule

// File: flash_cmd_props.sv
module flash_cmd_props
  import flash_seq_pkg::*;
#(
  parameter logic [ADDR_W-1:0] FLASH_BASE = 16'h8000,
  parameter int BLOCK_W = 13,
  parameter int NUM_BLOCKS = 4
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire cmd_wr_t CMD,
  input wire logic [1:0] REG_ADDR,
  input wire logic [DATA_W-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [DATA_W-1:0] REG_RDATA,
  input wire op_req_t OP_REQ,
  input wire op_rsp_t OP_RSP,
  input wire logic READ_STATUS_MODE,
  input wire err_code_t ERROR_CODE
);
  logic en, lk0, lk1, pend, pend_er;
  // Target check of the current command address against the shadowed guard bits
  wire [ADDR_W-1:0] off = CMD.addr - FLASH_BASE;
  wire [ADDR_W-1:0] blk = off >> BLOCK_W;
  wire ok_addr = CMD.addr >= FLASH_BASE && blk < NUM_BLOCKS && !(blk < PROT_BLOCKS && !en)
    && !(lk0 && blk == 0) && !(lk1 && blk == 1);
  // Shadow registers; gated by CE because the design freezes with it
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      {en, lk0, lk1, pend, pend_er} <= '0;
    end else if (CE) begin
      if (REG_WR && REG_ADDR == OFF_CTRL_A) en <= REG_WDATA[CTRL_A_REWRITE_EN_BIT];
      if (REG_WR && REG_ADDR == OFF_CTRL_B) lk0 <= REG_WDATA[CTRL_B_LOCK0_BIT];
      if (REG_WR && REG_ADDR == OFF_CTRL_B) lk1 <= REG_WDATA[CTRL_B_LOCK1_BIT];
      if (OP_REQ.prog || OP_REQ.erase) pend <= 1'b1;
      else if (OP_RSP.done) pend <= 1'b0;
      if (OP_REQ.prog || OP_REQ.erase) pend_er <= OP_REQ.erase;
    end
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  // First cycles are only checked from read array mode; the design also takes them in read status mode
  sequence first_of(logic [7:0] c);
    CE && CMD.valid && !READ_STATUS_MODE && ERROR_CODE == ERR_NONE && CMD.data == c;
  endsequence
  sequence second_cyc;
    CE && CMD.valid;
  endsequence
  a_prog_start: assert property (first_of(CMD_PROGRAM) ##1 second_cyc ##0
    (CMD.data != CMD_READ_ARRAY && ok_addr && CMD.addr == $past(CMD.addr))
    |=> OP_REQ.prog && OP_REQ.addr == $past(CMD.addr) && OP_REQ.data == $past(CMD.data))
    else $error("program not started");
  a_prog_reject: assert property (first_of(CMD_PROGRAM) ##1 second_cyc ##0
    (CMD.data != CMD_READ_ARRAY && (!ok_addr || CMD.addr != $past(CMD.addr)))
    |=> ERROR_CODE == ERR_SEQUENCE && READ_STATUS_MODE && !OP_REQ.prog)
    else $error("bad program accepted");
  a_erase_start: assert property (first_of(CMD_ERASE) ##1 second_cyc ##0
    (CMD.data == CMD_ERASE_CONFIRM && ok_addr) |=> OP_REQ.erase && !OP_REQ.prog)
    else $error("erase not started");
  a_erase_reject: assert property (first_of(CMD_ERASE) ##1 second_cyc ##0
    (CMD.data != CMD_READ_ARRAY && (CMD.data != CMD_ERASE_CONFIRM || !ok_addr))
    |=> ERROR_CODE == ERR_SEQUENCE && !OP_REQ.erase)
    else $error("bad erase accepted");
  a_abort_read: assert property ((first_of(CMD_PROGRAM) or first_of(CMD_ERASE))
    ##1 second_cyc ##0 CMD.data == CMD_READ_ARRAY
    |=> !READ_STATUS_MODE && !OP_REQ.prog && !OP_REQ.erase && ERROR_CODE == ERR_NONE)
    else $error("abort failed");
  a_clear_flags: assert property (CE && CMD.valid && !READ_STATUS_MODE &&
    CMD.data == CMD_CLEAR_STATUS |=> ERROR_CODE == ERR_NONE)
    else $error("flags not cleared");
  a_refuse_err: assert property (CE && CMD.valid && !READ_STATUS_MODE &&
    ERROR_CODE != ERR_NONE && (CMD.data == CMD_PROGRAM || CMD.data == CMD_ERASE)
    |=> $stable(ERROR_CODE) && !READ_STATUS_MODE)
    else $error("command taken with flags set");
  a_fail_code: assert property (CE && pend && OP_RSP.done |=> ERROR_CODE ==
    (!$past(OP_RSP.fail) ? ERR_NONE : $past(pend_er) ? ERR_ERASE : ERR_PROGRAM))
    else $error("wrong code after completion");
  a_flag_read: assert property (CE && REG_RD && REG_ADDR == OFF_STATUS |=>
    REG_RDATA[STATUS_ERASE_BIT] == $past(ERROR_CODE[1])
    && REG_RDATA[STATUS_PROG_BIT] == $past(ERROR_CODE[0]))
    else $error("status byte flags differ");
endmodule

bind flash_command_error_status flash_cmd_props #(.FLASH_BASE(FLASH_BASE),
  .BLOCK_W(BLOCK_W), .NUM_BLOCKS(NUM_BLOCKS)) u_props (.MCLK(MCLK), .RST_N(RST_N),
  .CE(CE), .CMD(CMD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
  .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .OP_REQ(OP_REQ), .OP_RSP(OP_RSP),
  .READ_STATUS_MODE(READ_STATUS_MODE), .ERROR_CODE(ERROR_CODE));

// File: tb.sv
module tb import flash_seq_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic MCLK = 0, RST_N = 0, CE = 1, REG_WR = 0, REG_RD = 0, fail_en = 0;
  logic [1:0] REG_ADDR = '0;
  logic [7:0] REG_WDATA = '0, REG_RDATA;
  logic [2:0] lat = '0;
  cmd_wr_t CMD = '0;
  op_req_t OP_REQ;
  op_rsp_t OP_RSP;
  logic READ_STATUS_MODE;
  err_code_t ERROR_CODE;
  int n_mismatch = 0, tests_run = 0;
  logic [31:0] r = 32'hD1DBD38E;
  // Block boundaries, one mid-block address and the one unmapped corner below the base
  logic [15:0] tbl [8] = '{16'h7FFF, 16'h8000, 16'h9FFF, 16'hA000, 16'hBFFF, 16'hC000,
    16'hE123, 16'hFFFF};
  flash_command_error_status u_dut (.MCLK(MCLK), .RST_N(RST_N), .CE(CE), .CMD(CMD),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .OP_REQ(OP_REQ), .OP_RSP(OP_RSP),
    .READ_STATUS_MODE(READ_STATUS_MODE), .ERROR_CODE(ERROR_CODE));
  flash_engine_model u_eng (.mclk(MCLK), .req(OP_REQ), .fail_en(fail_en), .lat(lat),
    .rsp(OP_RSP));
  initial forever #20 MCLK = ~MCLK;
  function logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
  endfunction
  // Expected flags for a two-cycle program or erase entry
  function err_code_t exp_f(input logic [7:0] op, d2, input logic [15:0] a1, a2,
    input logic en, l0, l1, fl);
    if (d2 == CMD_READ_ARRAY) return ERR_NONE;
    if (op == CMD_ERASE ? d2 != CMD_ERASE_CONFIRM : a2 != a1) return ERR_SEQUENCE;
    if (a2 < 16'h8000 || !en || (l0 && a2[14:13] == 2'h0) || (l1 && a2[14:13] == 2'h1))
      return ERR_SEQUENCE;
    if (!fl) return ERR_NONE;
    return op == CMD_ERASE ? ERR_ERASE : ERR_PROGRAM;
  endfunction
  task chk(input bit ok, input string m);
    tests_run++;
    if (!ok) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  task wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge MCLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge MCLK);
    REG_WR <= 1'b0;
  endtask
  task rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge MCLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge MCLK);
    REG_RD <= 1'b0;
    #1 d = REG_RDATA;
  endtask
  // Second cycle follows the first with no gap
  task cmd(input logic [7:0] d1, input logic [15:0] a1, input bit two,
    input logic [7:0] d2, input logic [15:0] a2);
    @(posedge MCLK);
    CMD <= '{1'b1, a1, d1};
    if (two) begin
      @(posedge MCLK);
      CMD <= '{1'b1, a2, d2};
    end
    @(posedge MCLK);
    CMD <= '0;
    #1;
  endtask
  task stop_test;
    $display("mismatches %0d checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge MCLK);
    n_mismatch++;
    stop_test;
  end
  initial begin
    logic [7:0] op, d2, d;
    logic [15:0] a1, a2;
    logic en, l0, l1;
    err_code_t ex;
    repeat (4) @(posedge MCLK);
    RST_N <= 1'b1;
    rd(OFF_STATUS, d);
    chk(d[7:4] === 4'h8, "status after reset");
    cmd(8'h33, 16'h8000, 1'b0, 8'h0, 16'h0);
    chk(ERROR_CODE === ERR_SEQUENCE, "unknown code");
    cmd(CMD_READ_ARRAY, 16'h8000, 1'b0, 8'h0, 16'h0);
    cmd(CMD_CLEAR_STATUS, 16'h8000, 1'b0, 8'h0, 16'h0);
    for (int i = 0; i < 80; i++) begin
      r = lfsr(r);
      en = r[2] | r[3];
      l0 = r[5] & r[4];
      l1 = r[6] & r[4];
      wr(OFF_CTRL_A, {r[11:7], en, r[1:0]});
      wr(OFF_CTRL_B, {1'b0, l1, l0, 5'h0});
      wr(OFF_STATUS, 8'hFF);
      r = lfsr(r);
      op = r[0] ? CMD_ERASE : CMD_PROGRAM;
      a1 = tbl[r[3:1]];
      a2 = r[4] ? a1 : tbl[r[7:5]];
      d2 = r[10:8] == 0 ? CMD_READ_ARRAY : (r[10:8] == 1 || !r[0]) ? r[31:24] : CMD_ERASE_CONFIRM;
      fail_en <= r[11];
      lat <= r[14:12];
      ex = exp_f(op, d2, a1, a2, en, l0, l1, r[11]);
      cmd(op, a1, 1'b1, d2, a2);
      if (exp_f(op, d2, a1, a2, en, l0, l1, 1'b0) == ERR_NONE && d2 != CMD_READ_ARRAY) begin
        // Look just after each edge so the engine's done pulse has settled
        for (int k = 0; k < 20 && OP_RSP.done !== 1'b1; k++) begin
          @(posedge MCLK);
          #1;
        end
        @(posedge MCLK);
        #1;
      end
      chk(ERROR_CODE === ex, "error code");
      rd(OFF_STATUS, d);
      chk(d[5:4] === ex, "status flags");
      rd(OFF_CTRL_A, d);
      chk({d[7:6], d[2]} === {ex, en}, "control flags");
      rd(OFF_CTRL_B, d);
      chk(d[6:5] === {l1, l0}, "lock bits");
      cmd(CMD_READ_ARRAY, a1, 1'b0, 8'h0, 16'h0);
      if (ex != ERR_NONE) begin
        cmd(op, a1, 1'b0, 8'h0, 16'h0);
        chk(ERROR_CODE === ex && READ_STATUS_MODE === 1'b0, "refusal");
      end
      cmd(CMD_CLEAR_STATUS, a1, 1'b0, 8'h0, 16'h0);
      chk(ERROR_CODE === ERR_NONE, "clear");
      // A bad code offered while CE is low must leave every flag frozen
      @(posedge MCLK);
      CE <= 1'b0;
      CMD <= '{1'b1, a1, 8'h33};
      @(posedge MCLK);
      CE <= 1'b1;
      CMD <= '0;
      #1;
      chk(ERROR_CODE === ERR_NONE && READ_STATUS_MODE === 1'b0, "frozen by CE");
    end
    stop_test;
  end
endmodule
